// ===== hw/ipdp_map.svh
// Encodings, field positions, reset values and latencies of the integer pipeline.
`ifndef IPDP_MAP_SVH
`define IPDP_MAP_SVH
`define IPDP_RESET_PC  64'h0000_0000_0000_0000
`define IPDP_PC_STEP   64'h0000_0000_0000_0004
`define IPDP_BR_SHIFT  2
`define IPDP_ZERO_REG  5'h00
`define IPDP_F_OP      31:26
`define IPDP_F_RS      25:21
`define IPDP_F_RT      20:16
`define IPDP_F_RD      15:11
`define IPDP_F_FN      5:0
`define IPDP_F_IMM     15:0
`define IPDP_FN_DIV    1
`define IPDP_FN_DW     2
`define IPDP_WSEL      2
`define IPDP_OP_RTYPE  6'h00
`define IPDP_OP_BEQ    6'h04
`define IPDP_OP_ADDI   6'h08
`define IPDP_OP_LW     6'h23
`define IPDP_OP_SW     6'h2b
`define IPDP_OP_LD     6'h37
`define IPDP_OP_SD     6'h3f
`define IPDP_FN_SLL    6'h00
`define IPDP_FN_SRL    6'h02
`define IPDP_FN_SRA    6'h03
`define IPDP_FN_MFU    6'h10
`define IPDP_FN_MFL    6'h12
`define IPDP_FN_MUL32  6'h18
`define IPDP_FN_DIV32  6'h1a
`define IPDP_FN_MUL64  6'h1c
`define IPDP_FN_DIV64  6'h1e
`define IPDP_FN_ADD    6'h20
`define IPDP_FN_SUB    6'h22
`define IPDP_FN_AND    6'h24
`define IPDP_FN_OR     6'h25
`define IPDP_FN_XOR    6'h26
`define IPDP_BE_LO     8'h0f
`define IPDP_BE_HI     8'hf0
`define IPDP_BE_ALL    8'hff
`define IPDP_LAT_MUL32 7'h06
`define IPDP_LAT_MUL64 7'h07
`define IPDP_LAT_DIV32 7'h2a
`define IPDP_LAT_DIV64 7'h4a
`endif

// ===== hw/ipdp_pkg.sv
// Types and helpers shared by the integer pipeline modules.
package ipdp_pkg;
    typedef logic [63:0] ipdp_word_t;
    typedef enum logic [2:0] {
        IPDP_ADD = 3'h0,
        IPDP_SUB = 3'h1,
        IPDP_AND = 3'h2,
        IPDP_OR  = 3'h3,
        IPDP_XOR = 3'h4,
        IPDP_SLL = 3'h5,
        IPDP_SRL = 3'h6,
        IPDP_SRA = 3'h7
    } ipdp_aluop_e;
    typedef struct packed {
        ipdp_aluop_e aluOp;
        logic        useImm;
        logic        useRt;
        logic        wr;
        logic [4:0]  dst;
        logic        ld;
        logic        st;
        logic        dw;
        logic        br;
        logic        md;
        logic        mdDiv;
        logic        mdDw;
        logic        mfu;
        logic        mfl;
    } ipdp_ctl_s;
    function automatic ipdp_word_t ipdp_sext32(input ipdp_word_t v);
        return {{32{v[31]}}, v[31:0]};
    endfunction
endpackage

// ===== hw/ipdp_muldiv.sv
// Multiply/divide unit with upper and lower product registers and latency counter.
`timescale 1ns/1ps
`include "ipdp_map.svh"
module ipdp_muldiv #(
    parameter int CW = 7
) (
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    input  wire logic           start,
    input  wire logic           isDiv,
    input  wire logic           isDword,
    input  wire ipdp_pkg::ipdp_word_t opA,
    input  wire ipdp_pkg::ipdp_word_t opB,
    output logic                busy,
    output ipdp_pkg::ipdp_word_t upperProductReg_q,
    output ipdp_pkg::ipdp_word_t lowerProductReg_q
);
    import ipdp_pkg::*;

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [CW-1:0] lat;
    logic [1:0]    extra;
    logic [127:0]  product;
    ipdp_word_t    aOp;
    ipdp_word_t    bOp;
    ipdp_word_t    quot;
    ipdp_word_t    rem;
    ipdp_word_t    upperRaw;
    ipdp_word_t    lowerRaw;

    function automatic logic [1:0] popc3(input logic [2:0] f);
        return 2'(f[0]) + 2'(f[1]) + 2'(f[2]);
    endfunction

    // Operands are unsigned; a 32-bit operation looks at the low words only.
    assign aOp = isDword ? opA : {32'h0000_0000, opA[31:0]};
    assign bOp = isDword ? opB : {32'h0000_0000, opB[31:0]};
    assign product = 128'(aOp) * 128'(bOp);
    // Divide by zero gives all ones and keeps the dividend as remainder.
    assign quot = (bOp == '0) ? '1 : aOp / bOp;
    assign rem  = (bOp == '0) ? aOp : aOp % bOp;
    assign lowerRaw = isDiv ? quot : product[63:0];
    assign upperRaw = isDiv ? rem : (isDword ? product[127:64] : {32'h0000_0000, product[63:32]});
    // Early exit: each non-zero upper group of the multiplier adds one cycle.
    assign extra = isDword ? popc3({|opB[63:48], |opB[47:32], |opB[31:16]})
                           : popc3({|opB[31:24], |opB[23:16], |opB[15:8]}); // see RULE9
    assign lat = isDiv ? (isDword ? CW'(`IPDP_LAT_DIV64) : CW'(`IPDP_LAT_DIV32)) // see RULE10
                       : (isDword ? CW'(`IPDP_LAT_MUL64) : CW'(`IPDP_LAT_MUL32)) + CW'(extra);
    assign busy = (count_q != '0);
    assign count_d = start ? lat - CW'(1) : (busy ? count_q - CW'(1) : count_q);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // Results land at start; the counter hides them until the latency has run.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            upperProductReg_q <= '0;
            lowerProductReg_q <= '0;
        end else if (start) begin
            upperProductReg_q <= isDword ? upperRaw : ipdp_sext32(upperRaw); // see RULE7
            lowerProductReg_q <= isDword ? lowerRaw : ipdp_sext32(lowerRaw); // see RULE7
        end
    end

    default clocking mdCb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence sMul32;
        start && !isDiv && !isDword;
    endsequence
    sequence sMul64;
        start && !isDiv && isDword;
    endsequence

    chk_mul32_latency: assert property (sMul32 |=> busy [*5] ##[1:4] !busy) // see RULE9
        else $error("32-bit multiply latency outside six to nine cycles");
    chk_mul64_latency: assert property (sMul64 |=> busy [*6] ##[1:4] !busy) // see RULE9
        else $error("64-bit multiply latency outside seven to ten cycles");
    chk_div32_latency: assert property (start && isDiv && !isDword |=> ##40 busy ##1 !busy) // see RULE10
        else $error("32-bit divide latency is not 42 cycles");
    chk_div64_latency: assert property (start && isDiv && isDword |=> ##72 busy ##1 !busy) // see RULE10
        else $error("64-bit divide latency is not 74 cycles");
endmodule

// ===== hw/ipdp_core.sv
// Five-stage integer pipeline: fetch, read, execute, data access and write-back.
// How it works
// RULE1: Instructions flow through fetch, read, execute, data access, write-back stages.
// RULE2: Thirty-two general registers, each sixty-four bits wide.
// RULE3: Two read ports, one write port, results bypassed before write-back.
// RULE4: Adder and logic unit finish each operation in one cycle.
// RULE5: Adder does arithmetic and addresses; logic unit does logic and shifts.
// RULE6: Multiply and divide run in a separate autonomous unit.
// RULE7: Results go to upper and lower product registers; moves copy them out.
// RULE8: A move from a product register stalls until the result is ready.
// RULE9: Multiply takes six to nine cycles for 32 bits, seven to ten for 64.
// RULE10: Divide takes 42 cycles for 32 bits and 74 for 64 bits.
// RULE11: Instruction cache accessed from fetch into read; translation during fetch.
// RULE12: Read stage reads registers, selects bypass, decodes, computes branch target; here the bypass is selected in execute.
// RULE13: Execute decides slip, computes data address, resolves branch, runs ALU.
// RULE14: Store aligned in execute; data access and load align through data stage.
// RULE15: Data address presented for translation in the data access stage.
// RULE16: Results written to the register file at the end of write-back.
// RULE17: Register zero reads as zero and ignores writes.
// RULE18: Without a slip, one new instruction is fetched every cycle.
`timescale 1ns/1ps
`include "ipdp_map.svh"
module ipdp_core (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    output ipdp_pkg::ipdp_word_t       imemAddr,
    input  wire logic [31:0]           imemData,
    output ipdp_pkg::ipdp_word_t       dmemAddr,
    output logic                       dmemRd,
    output logic                       dmemWr,
    output logic [7:0]                 dmemByteEn,
    output ipdp_pkg::ipdp_word_t       dmemWdata,
    input  wire ipdp_pkg::ipdp_word_t  dmemRdata,
    output logic                       pipeSlip,
    output logic                       retireEn,
    output logic [4:0]                 retireIdx,
    output ipdp_pkg::ipdp_word_t       retireData
);
    import ipdp_pkg::*;

    ipdp_word_t  pc_q;
    ipdp_word_t  fetchAddr;
    logic        rdValid_q;
    ipdp_word_t  rdPc_q;
    logic [31:0] rdInstr_q;
    ipdp_ctl_s   rdCtl;
    ipdp_word_t  rdImm;
    ipdp_word_t  rdTarget;
    logic        exValid_q;
    ipdp_ctl_s   exCtl_q;
    logic [4:0]  exRs_q;
    logic [4:0]  exRt_q;
    ipdp_word_t  exImm_q;
    ipdp_word_t  exTarget_q;
    ipdp_word_t  exRsRaw_q;
    ipdp_word_t  exRtRaw_q;
    ipdp_word_t  rsRead;
    ipdp_word_t  rtRead;
    ipdp_word_t  rsFwd;
    ipdp_word_t  rtFwd;
    ipdp_word_t  opB;
    ipdp_word_t  aluRes;
    ipdp_word_t  exRes;
    ipdp_word_t  stData;
    logic [7:0]  stBe;
    logic        taken;
    logic        loadUse;
    logic        mdWait;
    logic        slip;
    logic        mdStart;
    logic        mdBusy;
    ipdp_word_t  upperProductReg;
    ipdp_word_t  lowerProductReg;
    logic        dcValid_q;
    ipdp_ctl_s   dcCtl_q;
    ipdp_word_t  dcRes_q;
    ipdp_word_t  dcStData_q;
    logic [7:0]  dcBe_q;
    ipdp_word_t  ldWord;
    ipdp_word_t  ldVal;
    logic        wbWrEn_q;
    logic [4:0]  wbIdx_q;
    ipdp_word_t  wbData_q;
    ipdp_word_t  rf_q [32];

    function automatic ipdp_ctl_s decode(input logic [31:0] ins);
        ipdp_ctl_s c;
        c = '0;
        c.aluOp = IPDP_ADD;
        c.dst = ins[`IPDP_F_RT];
        case (ins[`IPDP_F_OP])
            `IPDP_OP_ADDI: begin
                c.useImm = 1'b1;
                c.wr = 1'b1;
            end
            `IPDP_OP_LW, `IPDP_OP_LD: begin
                c.useImm = 1'b1;
                c.wr = 1'b1;
                c.ld = 1'b1;
                c.dw = (ins[`IPDP_F_OP] == `IPDP_OP_LD);
            end
            `IPDP_OP_SW, `IPDP_OP_SD: begin
                c.useImm = 1'b1;
                c.useRt = 1'b1;
                c.st = 1'b1;
                c.dw = (ins[`IPDP_F_OP] == `IPDP_OP_SD);
            end
            `IPDP_OP_BEQ: begin
                c.useRt = 1'b1;
                c.br = 1'b1;
            end
            `IPDP_OP_RTYPE: begin
                c.useRt = 1'b1;
                c.wr = 1'b1;
                c.dst = ins[`IPDP_F_RD];
                case (ins[`IPDP_F_FN])
                    `IPDP_FN_ADD: c.aluOp = IPDP_ADD;
                    `IPDP_FN_SUB: c.aluOp = IPDP_SUB;
                    `IPDP_FN_AND: c.aluOp = IPDP_AND;
                    `IPDP_FN_OR:  c.aluOp = IPDP_OR;
                    `IPDP_FN_XOR: c.aluOp = IPDP_XOR;
                    `IPDP_FN_SLL: c.aluOp = IPDP_SLL;
                    `IPDP_FN_SRL: c.aluOp = IPDP_SRL;
                    `IPDP_FN_SRA: c.aluOp = IPDP_SRA;
                    `IPDP_FN_MFU: c.mfu = 1'b1;
                    `IPDP_FN_MFL: c.mfl = 1'b1;
                    `IPDP_FN_MUL32, `IPDP_FN_DIV32, `IPDP_FN_MUL64, `IPDP_FN_DIV64: begin
                        c.wr = 1'b0;
                        c.md = 1'b1;
                        c.mdDiv = ins[`IPDP_FN_DIV];
                        c.mdDw = ins[`IPDP_FN_DW];
                    end
                    default: c.wr = 1'b0;
                endcase
            end
            default: c = '0;
        endcase
        return c;
    endfunction

    // Adder serves arithmetic and addresses; logic unit does logic and shifts.
    function automatic ipdp_word_t alu(input ipdp_aluop_e op, input ipdp_word_t a,
                                       input ipdp_word_t b);
        case (op)
            IPDP_ADD: return a + b;
            IPDP_SUB: return a - b;
            IPDP_AND: return a & b;
            IPDP_OR:  return a | b;
            IPDP_XOR: return a ^ b;
            IPDP_SLL: return a << b[5:0];
            IPDP_SRL: return a >> b[5:0];
            default:  return ipdp_word_t'($signed(a) >>> b[5:0]);
        endcase
    endfunction

    // Register read with write-through from the write-back port.
    function automatic ipdp_word_t rfRead(input logic [4:0] idx);
        if (idx == `IPDP_ZERO_REG) return '0;
        if (wbWrEn_q && wbIdx_q == idx) return wbData_q;
        return rf_q[idx];
    endfunction

    // Bypass from the data stage and the write-back stage, youngest first.
    function automatic ipdp_word_t fwd(input logic [4:0] idx, input ipdp_word_t raw);
        if (idx == `IPDP_ZERO_REG) return '0;
        if (dcValid_q && dcCtl_q.wr && dcCtl_q.dst == idx) return dcRes_q;
        if (wbWrEn_q && wbIdx_q == idx) return wbData_q;
        return raw;
    endfunction

    // Read stage: decode, immediate and branch target.
    assign rdCtl = decode(rdInstr_q); // see RULE12
    assign rdImm = {{48{rdInstr_q[15]}}, rdInstr_q[`IPDP_F_IMM]};
    assign rdTarget = rdPc_q + `IPDP_PC_STEP + (rdImm << `IPDP_BR_SHIFT); // see RULE12

    // During a slip the held execute operands are read again, so a result that
    // retires while the stage waits is not lost.
    always_comb begin
        rsRead = rfRead(slip ? exRs_q : rdInstr_q[`IPDP_F_RS]); // see RULE3
        rtRead = rfRead(slip ? exRt_q : rdInstr_q[`IPDP_F_RT]); // see RULE3
        rsFwd = fwd(exRs_q, exRsRaw_q); // see RULE12
        rtFwd = fwd(exRt_q, exRtRaw_q); // see RULE3
        ldWord = dcRes_q[`IPDP_WSEL] ? {32'h0000_0000, dmemRdata[63:32]} : dmemRdata;
        ldVal = dcCtl_q.dw ? dmemRdata : ipdp_sext32(ldWord); // see RULE14
    end

    // Execute stage.
    assign opB = exCtl_q.useImm ? exImm_q : rtFwd;
    assign aluRes = alu(exCtl_q.aluOp, rsFwd, opB); // see RULE4
    assign exRes = exCtl_q.mfu ? upperProductReg
                 : (exCtl_q.mfl ? lowerProductReg : aluRes); // see RULE7
    assign loadUse = exValid_q && dcValid_q && dcCtl_q.ld && dcCtl_q.dst != `IPDP_ZERO_REG
                   && (dcCtl_q.dst == exRs_q || (exCtl_q.useRt && dcCtl_q.dst == exRt_q));
    assign mdWait = exValid_q && (exCtl_q.mfu || exCtl_q.mfl || exCtl_q.md) && mdBusy; // see RULE8
    assign slip = loadUse || mdWait; // see RULE13
    assign taken = exValid_q && exCtl_q.br && !slip && rsFwd == rtFwd; // see RULE13
    assign stData = exCtl_q.dw ? rtFwd : {rtFwd[31:0], rtFwd[31:0]}; // see RULE14
    assign stBe = exCtl_q.dw ? `IPDP_BE_ALL
                : (aluRes[`IPDP_WSEL] ? `IPDP_BE_HI : `IPDP_BE_LO); // see RULE14
    assign mdStart = exValid_q && exCtl_q.md && !slip;
    // A taken branch redirects the fetch in the same cycle, leaving one delay slot.
    assign fetchAddr = taken ? exTarget_q : pc_q; // see RULE11

    ipdp_muldiv #(
        .CW(7)
    ) u_muldiv (
        .ref_clk           (ref_clk),
        .nrst              (nrst),
        .start             (mdStart),
        .isDiv             (exCtl_q.mdDiv),
        .isDword           (exCtl_q.mdDw),
        .opA               (rsFwd),
        .opB               (rtFwd),
        .busy              (mdBusy),
        .upperProductReg_q (upperProductReg),
        .lowerProductReg_q (lowerProductReg)
    ); // see RULE6

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= `IPDP_RESET_PC;
            rdValid_q <= 1'b0;
            rdPc_q <= '0;
            rdInstr_q <= '0;
        end else if (!slip) begin
            pc_q <= fetchAddr + `IPDP_PC_STEP; // see RULE18
            rdValid_q <= 1'b1;
            rdPc_q <= fetchAddr;
            rdInstr_q <= imemData; // see RULE11
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            exValid_q <= 1'b0;
            exCtl_q <= '0;
            exRs_q <= '0;
            exRt_q <= '0;
            exImm_q <= '0;
            exTarget_q <= '0;
        end else if (!slip) begin
            exValid_q <= rdValid_q; // see RULE1
            exCtl_q <= rdCtl;
            exRs_q <= rdInstr_q[`IPDP_F_RS];
            exRt_q <= rdInstr_q[`IPDP_F_RT];
            exImm_q <= rdImm;
            exTarget_q <= rdTarget;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            exRsRaw_q <= '0;
            exRtRaw_q <= '0;
        end else begin
            exRsRaw_q <= rsRead;
            exRtRaw_q <= rtRead;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dcValid_q <= 1'b0;
            dcCtl_q <= '0;
            dcRes_q <= '0;
            dcStData_q <= '0;
            dcBe_q <= '0;
        end else begin
            dcValid_q <= exValid_q && !slip; // see RULE1
            dcCtl_q <= exCtl_q;
            dcRes_q <= exRes; // see RULE5
            dcStData_q <= stData;
            dcBe_q <= stBe;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wbWrEn_q <= 1'b0;
            wbIdx_q <= '0;
            wbData_q <= '0;
        end else begin
            wbWrEn_q <= dcValid_q && dcCtl_q.wr && dcCtl_q.dst != `IPDP_ZERO_REG; // see RULE17
            wbIdx_q <= dcCtl_q.dst;
            wbData_q <= dcCtl_q.ld ? ldVal : dcRes_q;
        end
    end

    // Storage only; register zero is never written and reads as zero.
    always_ff @(posedge ref_clk) begin
        if (wbWrEn_q) begin
            rf_q[wbIdx_q] <= wbData_q; // see RULE16 see RULE2
        end
    end

    assign imemAddr = fetchAddr;
    assign dmemAddr = dcRes_q; // see RULE15
    assign dmemRd = dcValid_q && dcCtl_q.ld;
    assign dmemWr = dcValid_q && dcCtl_q.st;
    assign dmemByteEn = dcBe_q;
    assign dmemWdata = dcStData_q;
    assign pipeSlip = slip;
    assign retireEn = wbWrEn_q;
    assign retireIdx = wbIdx_q;
    assign retireData = wbData_q;

    default clocking coreCb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence sLoadDep;
        exValid_q && dcValid_q && dcCtl_q.ld && dcCtl_q.dst != `IPDP_ZERO_REG
            && dcCtl_q.dst == exRs_q;
    endsequence
    sequence sMoveWait;
        exValid_q && (exCtl_q.mfu || exCtl_q.mfl) && mdBusy;
    endsequence

    chk_move_interlock: assert property (sMoveWait |-> slip ##1 !dcValid_q) // see RULE8
        else $error("move from product register did not stall");
    chk_load_slip: assert property (sLoadDep |=> !dcValid_q && wbWrEn_q && wbIdx_q == exRs_q) // see RULE3
        else $error("load-use dependency not slipped and bypassed");
    chk_zero_discard: assert property (dcValid_q && dcCtl_q.dst == `IPDP_ZERO_REG |=> !wbWrEn_q) // see RULE17
        else $error("write to register zero not discarded");
    chk_fetch_rate: assert property (!slip && !taken |=> pc_q == $past(pc_q) + `IPDP_PC_STEP) // see RULE18
        else $error("fetch did not advance by one instruction");
    chk_branch_redirect: assert property (taken |=> rdPc_q == $past(exTarget_q)) // see RULE13
        else $error("taken branch did not redirect fetch");
    chk_store_stage: assert property (dmemWr |-> $past(exValid_q) && !$past(slip)) // see RULE14
        else $error("store reached data stage without leaving execute");
    chk_store_align: assert property (dmemWr && !dcCtl_q.dw |-> dmemWdata[63:32] == dmemWdata[31:0]
            && dmemByteEn == (dmemAddr[`IPDP_WSEL] ? `IPDP_BE_HI : `IPDP_BE_LO)) // see RULE14
        else $error("word store not aligned to its half of the data word");
    chk_wb_write: assert property (dcValid_q && dcCtl_q.wr && !dcCtl_q.ld
            && dcCtl_q.dst != `IPDP_ZERO_REG |=> wbWrEn_q && wbData_q == $past(dcRes_q)) // see RULE16
        else $error("result not written back one cycle after data stage");
endmodule

// ===== sim/ipdp_mem_model.sv
// Behavioural instruction and data memory that answers within the same cycle.
`timescale 1ns/1ps
module ipdp_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [63:0] imemAddr,
    output logic      [31:0] imemData,
    input  wire logic [63:0] dmemAddr,
    input  wire logic        dmemRd,
    input  wire logic        dmemWr,
    input  wire logic [7:0]  dmemByteEn,
    input  wire logic [63:0] dmemWdata,
    output logic      [63:0] dmemRdata
);
    logic [31:0] imem [64];
    logic [63:0] dmem [32];
    logic [63:0] lastRd_q = 64'h0;
    assign imemData  = imem[imemAddr[7:2]];
    // Outside a load the bus shows the inverse of the last value, so stale data never matches.
    assign dmemRdata = dmemRd ? dmem[dmemAddr[7:3]] : ~lastRd_q;
    always @(posedge ref_clk) begin
        if (dmemRd) lastRd_q <= dmemRdata;
        for (int b = 0; b < 8; b++) begin
            if (dmemWr && dmemByteEn[b]) dmem[dmemAddr[7:3]][b*8 +: 8] <= dmemWdata[b*8 +: 8];
        end
    end
endmodule

// ===== sim/test_integer_pipeline_datapath.sv
// Self-checking bench for the integer pipeline core.
`timescale 1ns/1ps
`include "ipdp_map.svh"
module test_integer_pipeline_datapath;
    import ipdp_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    ipdp_word_t  imemAddr, dmemAddr, dmemWdata, dmemRdata, retireData;
    logic [31:0] imemData;
    logic        dmemRd, dmemWr, pipeSlip, retireEn;
    logic [7:0]  dmemByteEn;
    logic [4:0]  retireIdx;
    ipdp_word_t  shadow [32];
    int          error_cnt = 0, check_count = 0, slips = 0, zeroWr = 0, cyc = 0;
    ipdp_core u_ipdp_core (.ref_clk, .nrst, .imemAddr, .imemData, .dmemAddr, .dmemRd, .dmemWr,
        .dmemByteEn, .dmemWdata, .dmemRdata, .pipeSlip, .retireEn, .retireIdx, .retireData);
    ipdp_mem_model u_ipdp_mem_model (.ref_clk, .imemAddr, .imemData, .dmemAddr, .dmemRd,
        .dmemWr, .dmemByteEn, .dmemWdata, .dmemRdata);
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (pipeSlip === 1'b1) slips <= slips + 1;
        if (retireEn === 1'b1) begin
            shadow[retireIdx] <= retireData;
            if (retireIdx === `IPDP_ZERO_REG) zeroWr <= zeroWr + 1;
        end
        // The whole sequence needs about six hundred cycles.
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] rop(input logic [5:0] fn, input logic [4:0] rs, rt, rd);
        return {`IPDP_OP_RTYPE, rs, rt, rd, 5'h00, fn};
    endfunction
    function automatic logic [31:0] iop(input logic [5:0] op, input logic [4:0] rs, rt,
                                        input logic [15:0] imm);
        return {op, rs, rt, imm};
    endfunction
    task automatic chk(input string what, input ipdp_word_t seen, exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Programs are loaded under reset so the core never runs a half-written image.
    task automatic load(input logic [31:0] p[$]);
        nrst = 1'b0;
        foreach (u_ipdp_mem_model.imem[i]) u_ipdp_mem_model.imem[i] = (i < p.size()) ? p[i] : 32'h0;
    endtask
    task automatic run(input int n);
        repeat (16) @(posedge ref_clk);
        #1 nrst = 1'b1;
        slips = 0;
        zeroWr = 0;
        foreach (shadow[i]) shadow[i] = 64'hbad;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic test_alu();
        load({iop(`IPDP_OP_ADDI, 0, 1, 16'h0005), iop(`IPDP_OP_ADDI, 0, 2, 16'h0003),
              rop(`IPDP_FN_ADD, 1, 2, 3), rop(`IPDP_FN_SUB, 2, 1, 4), rop(`IPDP_FN_AND, 1, 2, 5),
              rop(`IPDP_FN_OR, 1, 2, 6), rop(`IPDP_FN_XOR, 1, 2, 7), rop(`IPDP_FN_SLL, 1, 2, 8),
              rop(`IPDP_FN_SRL, 4, 2, 9), rop(`IPDP_FN_SRA, 4, 2, 10),
              iop(`IPDP_OP_ADDI, 0, 0, 16'h0009), rop(`IPDP_FN_ADD, 0, 1, 11)});
        run(30);
        chk("add", shadow[3], 64'h8);
        chk("sub", shadow[4], 64'hffff_ffff_ffff_fffe);
        chk("and", shadow[5], 64'h1);
        chk("or", shadow[6], 64'h7);
        chk("xor", shadow[7], 64'h6);
        chk("sll", shadow[8], 64'h28);
        chk("srl", shadow[9], 64'h1fff_ffff_ffff_ffff);
        chk("sra", shadow[10], 64'hffff_ffff_ffff_ffff);
        chk("zero read", shadow[11], 64'h5);
        chk("zero writes", 64'(zeroWr), 64'h0);
        chk("alu slips", 64'(slips), 64'h0);
    endtask
    task automatic test_mem();
        load({iop(`IPDP_OP_ADDI, 0, 1, 16'h0005), iop(`IPDP_OP_ADDI, 0, 3, 16'h0008),
              iop(`IPDP_OP_SD, 0, 3, 16'h0100), iop(`IPDP_OP_SW, 0, 1, 16'h0104),
              iop(`IPDP_OP_LD, 0, 6, 16'h0100), rop(`IPDP_FN_ADD, 6, 0, 10),
              iop(`IPDP_OP_LW, 0, 9, 16'h0104)});
        run(30);
        chk("ld", shadow[6], 64'h0000_0005_0000_0008);
        chk("load use", shadow[10], 64'h0000_0005_0000_0008);
        chk("lw", shadow[9], 64'h5);
        chk("load slips", 64'(slips), 64'h1);
    endtask
    task automatic test_muldiv(input logic [5:0] fn, input logic [15:0] b, input ipdp_word_t lo,
                               hi, input int stall);
        load({iop(`IPDP_OP_ADDI, 0, 1, 16'h0064), iop(`IPDP_OP_ADDI, 0, 2, b),
              rop(fn, 1, 2, 0), rop(`IPDP_FN_MFL, 0, 0, 7), rop(`IPDP_FN_MFU, 0, 0, 8)});
        // Kept short so the fetch never wraps round the image and repeats the program.
        run(stall + 40);
        chk("lower product", shadow[7], lo);
        chk("upper product", shadow[8], hi);
        chk("move stall", 64'(slips), 64'(stall));
    endtask
    task automatic test_branch();
        load({iop(`IPDP_OP_BEQ, 0, 0, 16'h0002), iop(`IPDP_OP_ADDI, 0, 11, 16'h0001),
              iop(`IPDP_OP_ADDI, 0, 12, 16'h0001), iop(`IPDP_OP_ADDI, 0, 13, 16'h0001)});
        run(20);
        chk("delay slot", shadow[11], 64'h1);
        chk("skipped", shadow[12], 64'hbad);
        chk("target", shadow[13], 64'h1);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        test_alu();
        test_mem();
        test_muldiv(`IPDP_FN_MUL32, 16'h0007, 64'h2bc, 64'h0, 5);
        test_muldiv(`IPDP_FN_MUL32, 16'h0107, 64'h66bc, 64'h0, 6);
        test_muldiv(`IPDP_FN_MUL64, 16'h0007, 64'h2bc, 64'h0, 6);
        test_muldiv(`IPDP_FN_MUL64, 16'h8007, 64'hffff_ffff_ffce_02bc, 64'h63, 9);
        test_muldiv(`IPDP_FN_DIV32, 16'h0007, 64'he, 64'h2, 41);
        test_muldiv(`IPDP_FN_DIV64, 16'h0007, 64'he, 64'h2, 73);
        test_branch();
        tally_and_finish();
    end
endmodule
